// >>> design/irq_ctrl_pkg.sv
// register map, field positions and reset values of the prioritized interrupt controller
// assumes an APB slave with 32-bit data and byte addresses on paddr
package irq_ctrl_pkg;
    localparam int          ADDR_W               = 12;
    localparam int          DATA_W               = 32;
    localparam int          STRB_W               = 4;
    localparam int          PRI_W                = 4;
    localparam int          VEC_W                = 9;
    localparam int          NUM_SOFT             = 8;
    localparam int          BASE_W               = 21;
    localparam int          DEF_NUM_VEC          = 211;
    localparam int          DEF_LIFO_DEPTH       = 16;

    localparam logic [11:0] OFF_MODULE_CONFIG    = 12'h000;
    localparam logic [11:0] OFF_CURRENT_PRIORITY = 12'h008;
    localparam logic [11:0] OFF_INTERRUPT_ACK    = 12'h010;
    localparam logic [11:0] OFF_END_OF_INTERRUPT = 12'h018;
    localparam logic [11:0] OFF_SOFT_FLAG_0_3    = 12'h020;
    localparam logic [11:0] OFF_SOFT_FLAG_4_7    = 12'h024;
    localparam logic [11:0] OFF_PRIORITY_SELECT  = 12'h040;

    localparam int          HW_VECTOR_BIT        = 0;
    localparam int          ENTRY_SIZE_BIT       = 5;
    localparam int          SOFT_FLAG_BIT        = 0;
    localparam int          FLAG_SET_BIT         = 1;

    localparam logic        HW_VECTOR_RESET      = 1'h0;
    localparam logic        ENTRY_SIZE_RESET     = 1'h0;
    localparam logic [3:0]  PRIORITY_RESET       = 4'h0;
    localparam logic [7:0]  SOFT_FLAG_RESET      = 8'h00;
endpackage

// >>> design/priority_lifo.sv
// last-in-first-out store of preempted priorities
// assumes push and pop are never asked for together; the owner resolves that case
`timescale 1ns/1ns
module priority_lifo #(
    parameter int DEPTH = irq_ctrl_pkg::DEF_LIFO_DEPTH
) (
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic                           push,
    input  wire logic                           pop,
    input  wire logic [irq_ctrl_pkg::PRI_W-1:0] pushValue,
    output logic      [irq_ctrl_pkg::PRI_W-1:0] topValue,
    output logic      [$clog2(DEPTH+1)-1:0]     level
);
    import irq_ctrl_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][PRI_W-1:0] mem;
        logic [$clog2(DEPTH+1)-1:0]  ptr;
    } lifo_state_t;

    lifo_state_t s;
    lifo_state_t next_s;

    always_comb begin
        next_s = s;
        // a push onto a full store is dropped; an empty pop yields priority zero
        if (push && (int'(s.ptr) < DEPTH)) begin
            next_s.mem[s.ptr] = pushValue;
            next_s.ptr        = s.ptr + 1'b1;
        end else if (pop && (s.ptr != '0)) begin
            next_s.ptr = s.ptr - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign topValue = (s.ptr == '0) ? PRIORITY_RESET : s.mem[s.ptr - 1'b1];
    assign level    = s.ptr;
endmodule

// >>> design/prioritized_interrupt_regs.sv
// prioritized interrupt controller: APB registers, arbitration, processor handshake
// assumes synchronous request inputs and a processor acknowledge one clock wide
`timescale 1ns/1ns
module prioritized_interrupt_regs #(
    parameter int NUM_VEC    = irq_ctrl_pkg::DEF_NUM_VEC,
    parameter int LIFO_DEPTH = irq_ctrl_pkg::DEF_LIFO_DEPTH
) (
    input  wire logic                                         clk,
    input  wire logic                                         reset,
    input  wire logic                                         psel,
    input  wire logic                                         penable,
    input  wire logic                                         pwrite,
    input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]              paddr,
    input  wire logic [irq_ctrl_pkg::DATA_W-1:0]              pwdata,
    input  wire logic [irq_ctrl_pkg::STRB_W-1:0]              pstrb,
    output logic      [irq_ctrl_pkg::DATA_W-1:0]              prdata,
    output logic                                              pready,
    output logic                                              pslverr,
    input  wire logic [NUM_VEC-irq_ctrl_pkg::NUM_SOFT-1:0]    periphReq,
    input  wire logic                                         irqAck,
    output logic                                              irqReq,
    output logic      [irq_ctrl_pkg::VEC_W-1:0]               irqVector,
    output logic                                              hwVectorEn
);
    import irq_ctrl_pkg::*;

    localparam int NUM_PSR_WORDS = (NUM_VEC + 3) / 4;

    typedef struct packed {
        logic                          hwVec;
        logic                          entrySize;
        logic [PRI_W-1:0]              curPri;
        logic [BASE_W-1:0]             tableBase;
        logic [VEC_W-1:0]              vecNum;
        logic [PRI_W-1:0]              pendPri;
        logic [NUM_SOFT-1:0]           softFlag;
        logic [NUM_VEC-1:0][PRI_W-1:0] srcPri;
        logic                          irqReq;
        logic [VEC_W-1:0]              vecOut;
        logic                          hwVecOut;
        logic [DATA_W-1:0]             prdata;
        logic                          pready;
        logic                          pslverr;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    logic                  access;
    logic                  fire;
    logic [ADDR_W-1:0]     wordAddr;
    logic [ADDR_W-3:0]     psrWord;
    logic                  isPsr;
    logic                  mapped;
    logic [DATA_W-1:0]     readWord;
    logic [DATA_W-1:0]     mcrWord;
    logic [DATA_W-1:0]     mergedWord;
    logic                  ackEvent;
    logic                  popEvent;
    logic                  lifoPush;
    logic                  lifoPop;
    logic [PRI_W-1:0]      lifoTop;
    logic [NUM_VEC-1:0]    srcReq;
    logic                  found;
    logic [VEC_W-1:0]      bestVec;
    logic [PRI_W-1:0]      bestPri;

    // byte-lane merge so that every access width lands only on its own lanes
    function automatic logic [DATA_W-1:0] laneMerge(
        input logic [DATA_W-1:0] oldWord,
        input logic [DATA_W-1:0] newWord,
        input logic [STRB_W-1:0] strb
    );
        logic [DATA_W-1:0] result;
        result = oldWord;
        for (int k = 0; k < STRB_W; k++) begin
            if (strb[k]) begin
                result[8*k +: 8] = newWord[8*k +: 8];
            end
        end
        return result;
    endfunction

    assign access   = psel & penable;
    assign fire     = access & s.pready;
    assign wordAddr = {paddr[ADDR_W-1:2], 2'b00};
    assign psrWord  = paddr[ADDR_W-1:2] - OFF_PRIORITY_SELECT[ADDR_W-1:2];
    assign isPsr    = (wordAddr >= OFF_PRIORITY_SELECT) && (int'(psrWord) < NUM_PSR_WORDS);
    assign srcReq   = {periphReq, s.softFlag};

    always_comb begin
        mcrWord                 = '0;
        mcrWord[HW_VECTOR_BIT]  = s.hwVec;
        mcrWord[ENTRY_SIZE_BIT] = s.entrySize;
    end

    // read mux; every lane is presented so any width reads correctly
    always_comb begin
        readWord = '0;
        mapped   = 1'b1;
        case (wordAddr)
            OFF_MODULE_CONFIG: begin
                readWord = mcrWord;
            end
            OFF_CURRENT_PRIORITY: begin
                readWord[PRI_W-1:0] = s.curPri;
            end
            OFF_INTERRUPT_ACK: begin
                // the entry size moves the vector up one bit and narrows the base
                if (s.entrySize) begin
                    readWord = {s.tableBase[BASE_W-1:1], s.vecNum, 3'h0};
                end else begin
                    readWord = {s.tableBase, s.vecNum, 2'h0};
                end
            end
            OFF_END_OF_INTERRUPT: begin
                readWord = '0;
            end
            OFF_SOFT_FLAG_0_3, OFF_SOFT_FLAG_4_7: begin
                // set bits always read back as zero
                for (int k = 0; k < STRB_W; k++) begin
                    readWord[8*k + SOFT_FLAG_BIT] = s.softFlag[4*int'(paddr[2]) + k];
                end
            end
            default: begin
                if (isPsr) begin
                    for (int k = 0; k < STRB_W; k++) begin
                        if (4*int'(psrWord) + k < NUM_VEC) begin
                            readWord[8*k +: PRI_W] = s.srcPri[4*int'(psrWord) + k];
                        end
                    end
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // pick the highest enabled priority above the mask; ties go to the lowest vector
    always_comb begin
        found   = 1'b0;
        bestVec = '0;
        bestPri = '0;
        for (int v = NUM_VEC - 1; v >= 0; v--) begin
            if (srcReq[v] && (s.srcPri[v] > s.curPri) && (!found || s.srcPri[v] >= bestPri)) begin
                found   = 1'b1;
                bestVec = VEC_W'(v);
                bestPri = s.srcPri[v];
            end
        end
    end

    // software reads in software mode, a live processor strobe in hardware mode
    always_comb begin
        ackEvent = 1'b0;
        if (s.hwVec) begin
            ackEvent = irqAck & s.irqReq;
        end else begin
            ackEvent = fire & ~pwrite & mapped & (wordAddr == OFF_INTERRUPT_ACK);
        end
    end

    // any write strobe pattern pops; data is never stored
    assign popEvent = fire & pwrite & (wordAddr == OFF_END_OF_INTERRUPT);
    assign lifoPush = ackEvent & ~popEvent;
    assign lifoPop  = popEvent & ~ackEvent;

    priority_lifo #(
        .DEPTH     (LIFO_DEPTH)
    ) u_lifo (
        .clk       (clk),
        .reset     (reset),
        .push      (lifoPush),
        .pop       (lifoPop),
        .pushValue (s.curPri),
        .topValue  (lifoTop),
        .level     ()
    );

    always_comb begin
        next_s     = s;
        mergedWord = laneMerge(readWord, pwdata, pstrb);

        // two-cycle APB answer: pready rises one cycle into the access phase
        next_s.pready  = access & ~s.pready;
        next_s.pslverr = access & ~s.pready & ~mapped;
        if (access && !s.pready) begin
            next_s.prdata = (pwrite || !mapped) ? '0 : readWord;
        end

        if (fire && pwrite && mapped) begin
            case (wordAddr)
                OFF_MODULE_CONFIG: begin
                    next_s.hwVec     = mergedWord[HW_VECTOR_BIT];
                    next_s.entrySize = mergedWord[ENTRY_SIZE_BIT];
                end
                OFF_CURRENT_PRIORITY: begin
                    next_s.curPri = mergedWord[PRI_W-1:0];
                end
                OFF_INTERRUPT_ACK: begin
                    // only the base is writable; the vector belongs to the arbiter
                    if (s.entrySize) begin
                        next_s.tableBase[BASE_W-1:1] = mergedWord[DATA_W-1:VEC_W+3];
                    end else begin
                        next_s.tableBase = mergedWord[DATA_W-1:VEC_W+2];
                    end
                end
                OFF_SOFT_FLAG_0_3, OFF_SOFT_FLAG_4_7: begin
                    for (int k = 0; k < STRB_W; k++) begin
                        if (pstrb[k]) begin
                            if (pwdata[8*k + FLAG_SET_BIT]) begin
                                next_s.softFlag[4*int'(paddr[2]) + k] = 1'b1;
                            end else if (pwdata[8*k + SOFT_FLAG_BIT]) begin
                                next_s.softFlag[4*int'(paddr[2]) + k] = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    if (isPsr) begin
                        for (int v = 0; v < NUM_VEC; v++) begin
                            if (int'(psrWord) == v / 4 && pstrb[v % 4]) begin
                                next_s.srcPri[v] = pwdata[8*(v % 4) +: PRI_W];
                            end
                        end
                    end
                end
            endcase
        end

        // handshake: acknowledge wins the priority; a lone pop restores the saved one
        if (ackEvent) begin
            next_s.curPri = s.pendPri;
            next_s.irqReq = 1'b0;
        end else if (lifoPop) begin
            next_s.curPri = lifoTop;
        end

        // the request waits one low cycle after an acknowledge before it can rise again
        if (!s.irqReq && !ackEvent && found) begin
            next_s.irqReq  = 1'b1;
            next_s.vecNum  = bestVec;
            next_s.pendPri = bestPri;
        end

        next_s.hwVecOut = next_s.hwVec;
        next_s.vecOut   = next_s.hwVec ? next_s.vecNum : '0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s           <= '0;
            s.hwVec     <= HW_VECTOR_RESET;
            s.entrySize <= ENTRY_SIZE_RESET;
            s.curPri    <= PRIORITY_RESET;
            s.softFlag  <= SOFT_FLAG_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign irqReq     = s.irqReq;
    assign irqVector  = s.vecOut;
    assign hwVectorEn = s.hwVecOut;
endmodule

// >>> tb/irq_regs_checker.sv
// port assertions for the interrupt controller, bound to its top module
// assumes all signals are sampled on the rising edge of clk
`timescale 1ns/1ns
module irq_regs_checker #(
    parameter int NUM_VEC    = 16,
    parameter int LIFO_DEPTH = 16
) (
    input wire logic                            clk,
    input wire logic                            reset,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [irq_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic                            pready,
    input wire logic                            pslverr,
    input wire logic                            irqAck,
    input wire logic                            irqReq,
    input wire logic [irq_ctrl_pkg::VEC_W-1:0]  irqVector,
    input wire logic                            hwVectorEn
);
    import irq_ctrl_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence setupPhase;
        psel && !penable;
    endsequence
    sequence accessPhase;
        psel && penable;
    endsequence
    sequence ackRead;
        psel && penable && pready && !pwrite && paddr[11:2] == OFF_INTERRUPT_ACK[11:2];
    endsequence
    a_one_wait_state: assert property (setupPhase ##1 accessPhase |-> !pready ##1 pready)
        else $error("bus answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_sw_vector_zero: assert property (!hwVectorEn && !$past(hwVectorEn) |-> irqVector == '0)
        else $error("vector not zero in software mode");
    a_sw_ack_drop: assert property ((!hwVectorEn && irqReq) ##0 ackRead |=> !irqReq)
        else $error("request kept after software acknowledge");
    a_hw_ack_drop: assert property (hwVectorEn && irqReq && irqAck |=> !irqReq)
        else $error("request kept after processor acknowledge");
    a_req_holds: assert property (hwVectorEn && irqReq && !irqAck |=> irqReq)
        else $error("request dropped without acknowledge");
    a_vector_stable: assert property (irqReq && $past(irqReq) && $stable(hwVectorEn)
        |-> $stable(irqVector))
        else $error("vector changed while request pending");
    a_reset_clear: assert property ($fell(reset) |-> !irqReq && !hwVectorEn && !pready)
        else $error("outputs not cleared by reset");
endmodule

bind prioritized_interrupt_regs irq_regs_checker #(
    .NUM_VEC(NUM_VEC),
    .LIFO_DEPTH(LIFO_DEPTH)
) checker_i (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
    .irqAck, .irqReq, .irqVector, .hwVectorEn);

// >>> tb/core_model.sv
// processor core model: acknowledges hardware-vectored requests
// assumes the controller holds its request until acknowledged
`timescale 1ns/1ns
module core_model (
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic                           irqReq,
    input  wire logic [irq_ctrl_pkg::VEC_W-1:0] irqVector,
    input  wire logic                           hwVectorEn,
    input  wire logic                           ackEnable,
    input  wire logic [3:0]                     ackWait,
    output logic                                irqAck,
    output logic      [irq_ctrl_pkg::VEC_W-1:0] takenVector
);
    import irq_ctrl_pkg::*;
    logic [3:0] waited;
    // software mode has no acknowledge line, so the model stays silent there
    always @(posedge clk) begin
        if (reset) begin
            irqAck <= 1'b0;
            waited <= 4'h0;
            takenVector <= '0;
        end else if (irqAck || !(hwVectorEn && irqReq && ackEnable)) begin
            // the strobe is one clock wide, then the request must be seen afresh
            irqAck <= 1'b0;
            waited <= 4'h0;
        end else if (waited == ackWait) begin
            irqAck <= 1'b1;
            takenVector <= irqVector;
        end else begin
            waited <= waited + 4'h1;
        end
    end
endmodule

// >>> tb/test_prioritized_interrupt_regs.sv
// self-checking bench: register accesses and processor handshake
// assumes a 100 MHz clock and a synchronous active-high reset
`timescale 1ns/1ns
module test_prioritized_interrupt_regs;
    import irq_ctrl_pkg::*;
    localparam logic [11:0] CFG = OFF_MODULE_CONFIG;
    localparam logic [11:0] PRI = OFF_CURRENT_PRIORITY;
    localparam logic [11:0] ACK = OFF_INTERRUPT_ACK;
    localparam logic [11:0] EOI = OFF_END_OF_INTERRUPT;
    localparam logic [11:0] SF  = OFF_SOFT_FLAG_0_3;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
    logic        irqReq, irqAck, hwVectorEn, ackEnable;
    logic [11:0] paddr, fa;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0]  pstrb, ackWait;
    logic [7:0]  periphReq;
    logic [8:0]  irqVector, takenVector;
    int          num_errors, n_compared, sh;
    prioritized_interrupt_regs #(.NUM_VEC(16), .LIFO_DEPTH(16)) uut (.clk, .reset, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .periphReq, .irqAck, .irqReq, .irqVector, .hwVectorEn);
    core_model core (.clk, .reset, .irqReq, .irqVector, .hwVectorEn, .ackEnable,
        .ackWait, .irqAck, .takenVector);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            finish_test;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rdata, exp);
    endtask
    task automatic waitReq(input logic lvl);
        int n;
        n = 0;
        while (irqReq !== lvl && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, irqReq}, {31'h0, lvl});
    endtask
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        num_errors++;
        finish_test;
    end
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b1, 50'h0};
        {periphReq, ackEnable, ackWait, num_errors, n_compared} = '0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(CFG, 32'h0);
        rd(PRI, 32'h0);
        rd(EOI, 32'h0);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        chk({31'h0, rerr}, 32'h1);
        wr(PRI, 32'hf, 4'h1);
        rd(PRI, 32'hf);
        for (int k = 0; k < 8; k++) begin
            fa = SF + 12'(k / 4 * 4);
            sh = 8 * (k % 4);
            wr(fa, 32'h2 << sh, 4'h1 << (k % 4));
            rd(fa, 32'h1 << sh);
            wr(fa, 32'h3 << sh, 4'hf);
            rd(fa, 32'h1 << sh);
            wr(fa, 32'h1 << sh, 4'hf);
            rd(fa, 32'h0);
        end
        wr(PRI, 32'h5, 4'hf);
        wr(OFF_PRIORITY_SELECT, 32'h5, 4'h1);
        wr(OFF_PRIORITY_SELECT + 12'h8, 32'h0700, 4'h2);
        wr(ACK, 32'habcde800, 4'hf);
        wr(SF, 32'h2, 4'h1);
        repeat (4) @(posedge clk);
        chk({31'h0, irqReq}, 32'h0);
        wr(PRI, 32'h4, 4'hf);
        waitReq(1'b1);
        chk({23'h0, irqVector}, 32'h0);
        rd(ACK, 32'habcde800);
        chk({31'h0, irqReq}, 32'h0);
        rd(PRI, 32'h5);
        periphReq[1] <= 1'b1;
        waitReq(1'b1);
        rd(ACK, 32'habcde824);
        rd(PRI, 32'h7);
        periphReq[1] <= 1'b0;
        rd(EOI, 32'h0);
        rd(PRI, 32'h7);
        wr(EOI, 32'hffffffff, 4'h1);
        rd(PRI, 32'h5);
        wr(EOI, 32'h0, 4'hf);
        rd(PRI, 32'h4);
        wr(CFG, 32'h20, 4'h1);
        waitReq(1'b1);
        rd(ACK, 32'habcde000);
        wr(SF, 32'h1, 4'h1);
        wr(EOI, 32'h0, 4'hf);
        wr(PRI, 32'h0, 4'hf);
        wr(CFG, 32'h21, 4'h1);
        @(posedge clk);
        chk({31'h0, hwVectorEn}, 32'h1);
        periphReq[1] <= 1'b1;
        waitReq(1'b1);
        chk({23'h0, irqVector}, 32'h9);
        rd(ACK, 32'habcde048);
        chk({31'h0, irqReq}, 32'h1);
        rd(PRI, 32'h0);
        ackWait <= 4'h6;
        ackEnable <= 1'b1;
        waitReq(1'b0);
        chk({23'h0, takenVector}, 32'h9);
        rd(PRI, 32'h7);
        periphReq[1] <= 1'b0;
        ackWait <= 4'h0;
        wr(SF, 32'h2, 4'h1);
        wr(EOI, 32'h0, 4'hf);
        repeat (6) @(posedge clk);
        rd(PRI, 32'h5);
        chk({23'h0, takenVector}, 32'h0);
        finish_test;
    end
endmodule
